// ===== hdl/packet_address_field_codec.sv
`include "addr_codec_cfg.svh"

// Operation
// - Plain address is seven destination octets then seven source octets.
// - Bit 0 of each octet is zero, one only on the final address octet.
// - Call characters are seven-bit ASCII shifted left into bits 7 to 1.
// - Short call signs are padded with shifted spaces before the identifier octet.
// - Identifier octet holds C/R, two reserved bits, four-bit identifier, extension.
// - Reserved identifier bits are sent as ones.
// - Identifier zero is the default for a station's first instance.
// - Octets go out destination first, each least significant bit first.
// - Repeater subfields follow the source, whose extension bit is then cleared.
// - Repeater subfields match others but bit 7 is has-been-repeated.
// - Sender clears the has-been-repeated bit; the repeater sets it.
// - Via a repeater, received frames whose last repeater subfield still has that bit clear are discarded.
// - Call octets carry only upper-case letters, digits and padding spaces.
// - Destination is compared with own address as it arrives, before frame end.
// - Up to eight chained repeaters, only the very last octet extended.
module packet_address_field_codec
    import addr_codec_pkg::*;
#(
    parameter int MAX_RPT = `MAX_RPT
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Transmit address request
    input  wire logic                   encStart,
    input  wire logic [41:0]            destCall,
    input  wire logic [2:0]             destLen,
    input  wire logic [3:0]             destSsid,
    input  wire logic                   destCr,
    input  wire logic [41:0]            srcCall,
    input  wire logic [2:0]             srcLen,
    input  wire logic [3:0]             srcSsid,
    input  wire logic                   srcSsidSet,
    input  wire logic                   srcCr,
    input  wire logic [3:0]             rptCount,
    input  wire logic [MAX_RPT*42-1:0]  rptCall,
    input  wire logic [MAX_RPT*3-1:0]   rptLen,
    input  wire logic [MAX_RPT*4-1:0]   rptSsid,
    output logic                        encBusy,
    // Transmit bit stream
    output logic                        txBit,
    output logic                        txBitValid,
    output logic                        txLast,
    input  wire logic                   txBitReady,
    // Receive octet stream
    input  wire logic                   rxStart,
    input  wire logic [7:0]             rxOctet,
    input  wire logic                   rxValid,
    // Own station address and via-repeater flag
    input  wire logic [41:0]            ownCall,
    input  wire logic [2:0]             ownLen,
    input  wire logic [3:0]             ownSsid,
    input  wire logic                   viaRepeater,
    // Receive results
    output logic                        destChecked,
    output logic                        addrForUs,
    output logic                        addrDone,
    output logic                        addrError,
    output logic                        frameDrop,
    output logic [3:0]                  rxRptCount,
    output logic [3:0]                  rxSrcSsid,
    output logic                        rxDestCr,
    output logic                        rxSrcCr
);
    tx_state_type tx_reg;
    tx_state_type tx_next;
    rx_state_type rx_reg;
    rx_state_type rx_next;

    logic [3:0] rptUsed;
    logic [3:0] lastSub;
    logic [2:0] rIdx;
    logic [6:0] encChar;
    logic [2:0] encLen;
    logic [3:0] encSsid;
    logic       encTop;
    logic [7:0] encOctet;
    logic       encLastOct;
    logic       pushValid;
    logic       pushReady;
    logic [8:0] popData;
    logic       popValid;
    logic       popReady;

    // Repeater count beyond the chain limit is clamped, not rejected
    assign rptUsed = (rptCount > 4'(MAX_RPT)) ? 4'(MAX_RPT) : rptCount;
    assign lastSub = 4'(rptUsed + 4'd1);
    assign rIdx    = 3'(tx_reg.sub - 4'd2);

    // Octet builder: pick subfield, then character or identifier octet
    always_comb begin
        if (tx_reg.sub == 4'd0) begin
            encChar = destCall[tx_reg.pos*7 +: 7];
            encLen  = destLen;
            encSsid = destSsid;
            encTop  = destCr;
        end else if (tx_reg.sub == 4'd1) begin
            encChar = srcCall[tx_reg.pos*7 +: 7];
            encLen  = srcLen;
            encSsid = srcSsidSet ? srcSsid : `SSID_DEFAULT;
            encTop  = srcCr;
        end else begin
            encChar = rptCall[rIdx*42 + tx_reg.pos*7 +: 7];
            encLen  = rptLen[rIdx*3 +: 3];
            encSsid = rptSsid[rIdx*4 +: 4];
            encTop  = `HBIT_TX;
        end
        encLastOct = (tx_reg.pos == `SSID_POS) && (tx_reg.sub == lastSub);
        if (tx_reg.pos == `SSID_POS) begin
            encOctet = {encTop, `RSV_DEFAULT, encSsid, encLastOct};
        end else if (tx_reg.pos < encLen) begin
            encOctet = {encChar, 1'b0};
        end else begin
            encOctet = {`CHAR_SPACE, 1'b0};
        end
    end

    assign pushValid = (tx_reg.state == ENC_RUN);

    octet_fifo #(
        .WIDTH (9),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inData   ({encLastOct, encOctet}),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (popData),
        .outValid (popValid),
        .outReady (popReady)
    );

    // Transmit next state: encoder walk and bit serializer
    always_comb begin
        tx_next  = tx_reg;
        popReady = 1'b0;
        case (tx_reg.state)
            ENC_IDLE: begin
                if (encStart) begin
                    tx_next.state = ENC_RUN;
                    tx_next.sub   = 4'd0;
                    tx_next.pos   = 3'd0;
                    tx_next.busy  = 1'b1;
                end
            end
            ENC_RUN: begin
                // A full FIFO holds the encoder on the same octet
                if (pushReady) begin
                    if (tx_reg.pos == `SSID_POS) begin
                        tx_next.pos = 3'd0;
                        if (encLastOct) begin
                            tx_next.state = ENC_IDLE;
                            tx_next.busy  = 1'b0;
                        end else begin
                            tx_next.sub = 4'(tx_reg.sub + 4'd1);
                        end
                    end else begin
                        tx_next.pos = 3'(tx_reg.pos + 3'd1);
                    end
                end
            end
            default: begin
                tx_next.state = ENC_IDLE;
                tx_next.busy  = 1'b0;
            end
        endcase
        // Serializer shifts right so bit 0 leaves first
        if (!tx_reg.txValid || (txBitReady && tx_reg.bitCnt == 3'd7)) begin
            tx_next.txValid = popValid;
            tx_next.txLast  = 1'b0;
            if (popValid) begin
                popReady        = 1'b1;
                tx_next.shReg   = popData[7:0];
                tx_next.lastOct = popData[8];
                tx_next.bitCnt  = 3'd0;
            end
        end else if (txBitReady) begin
            tx_next.shReg  = {1'b0, tx_reg.shReg[7:1]};
            tx_next.bitCnt = 3'(tx_reg.bitCnt + 3'd1);
            tx_next.txLast = tx_reg.lastOct && (tx_reg.bitCnt == 3'd6);
        end
    end

    // Receive parser helpers
    logic [6:0] rxChar;
    logic [6:0] ownChar;
    logic       rxExt;
    logic       charOk;
    logic       rxEnd;

    assign rxChar  = rxOctet[7:1];
    assign rxExt   = rxOctet[`BIT_EXT];
    assign ownChar = (rx_reg.pos < ownLen) ? ownCall[rx_reg.pos*7 +: 7] : `CHAR_SPACE;
    // Spaces are tolerated since they are the padding character
    assign charOk  = ((rxChar >= 7'h41) && (rxChar <= 7'h5a)) ||
                     ((rxChar >= 7'h30) && (rxChar <= 7'h39)) || (rxChar == `CHAR_SPACE);
    assign rxEnd   = rxValid && rxExt && (rx_reg.state == PAR_ADDR);

    // Receive next state: octet-by-octet address walk
    always_comb begin
        rx_next             = rx_reg;
        rx_next.done        = 1'b0;
        rx_next.destChecked = 1'b0;
        if (rxStart) begin
            rx_next.state   = PAR_ADDR;
            rx_next.sub     = 4'd0;
            rx_next.pos     = 3'd0;
            rx_next.match   = 1'b1;
            rx_next.lastH   = 1'b1;
            rx_next.charBad = 1'b0;
            rx_next.error   = 1'b0;
            rx_next.drop    = 1'b0;
            rx_next.forUs   = 1'b0;
        end else begin
            case (rx_reg.state)
                PAR_IDLE: begin
                end
                PAR_ADDR: begin
                    if (rxValid && rx_reg.pos != `SSID_POS) begin
                        if (rx_reg.sub == 4'd0 && rxChar != ownChar) begin
                            rx_next.match = 1'b0;
                        end
                        if (!charOk) begin
                            rx_next.charBad = 1'b1;
                        end
                        rx_next.pos = 3'(rx_reg.pos + 3'd1);
                        if (rxExt) begin
                            // End flag on a character octet: not a whole subfield
                            rx_next.state = PAR_REST;
                            rx_next.done  = 1'b1;
                            rx_next.error = 1'b1;
                            rx_next.drop  = 1'b1;
                        end
                    end else if (rxValid) begin
                        rx_next.pos = 3'd0;
                        rx_next.sub = 4'(rx_reg.sub + 4'd1);
                        if (rx_reg.sub == 4'd0) begin
                            rx_next.destCr      = rxOctet[`BIT_TOP];
                            rx_next.destChecked = 1'b1;
                            rx_next.forUs       = rx_reg.match &&
                                                  (rxOctet[`SSID_MSB:`SSID_LSB] == ownSsid);
                            if (rxOctet[`SSID_MSB:`SSID_LSB] != ownSsid) begin
                                rx_next.match = 1'b0;
                            end
                        end else if (rx_reg.sub == 4'd1) begin
                            rx_next.srcSsid = rxOctet[`SSID_MSB:`SSID_LSB];
                            rx_next.srcCr   = rxOctet[`BIT_TOP];
                        end else begin
                            rx_next.lastH = rxOctet[`BIT_TOP];
                        end
                        if (rxExt || rx_reg.sub == 4'(`MAX_SUBS - 4'd1)) begin
                            rx_next.state    = PAR_REST;
                            rx_next.done     = 1'b1;
                            rx_next.rptCount = (rx_reg.sub > 4'd1) ? 4'(rx_reg.sub - 4'd1) : 4'd0;
                            // Too short, too long, or bad characters reject the frame
                            rx_next.error    = !rxExt || (rx_reg.sub == 4'd0) || rx_reg.charBad;
                            rx_next.drop     = !rxExt || (rx_reg.sub == 4'd0) || rx_reg.charBad ||
                                               (viaRepeater && rx_reg.sub > 4'd1 &&
                                                !rxOctet[`BIT_TOP]);
                        end
                    end
                end
                PAR_REST: begin
                    // Rest of frame belongs to other blocks; wait for next start
                end
                default: begin
                    rx_next.state = PAR_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_reg       <= '0;
            tx_reg.state <= ENC_IDLE;
            rx_reg       <= '0;
            rx_reg.state <= PAR_IDLE;
        end else begin
            tx_reg <= tx_next;
            rx_reg <= rx_next;
        end
    end

    // Outputs taken straight from state bits
    assign encBusy     = tx_reg.busy;
    assign txBit       = tx_reg.shReg[0];
    assign txBitValid  = tx_reg.txValid;
    assign txLast      = tx_reg.txLast;
    assign destChecked = rx_reg.destChecked;
    assign addrForUs   = rx_reg.forUs;
    assign addrDone    = rx_reg.done;
    assign addrError   = rx_reg.error;
    assign frameDrop   = rx_reg.drop;
    assign rxRptCount  = rx_reg.rptCount;
    assign rxSrcSsid   = rx_reg.srcSsid;
    assign rxDestCr    = rx_reg.destCr;
    assign rxSrcCr     = rx_reg.srcCr;

    // Checks
    logic pushed;
    assign pushed = pushValid && pushReady;

    sequence encOpen;
        (tx_reg.state == ENC_IDLE) && encStart;
    endsequence

    sequence encFirstOctet;
        pushValid && (tx_reg.sub == 4'd0) && (tx_reg.pos == 3'd0);
    endsequence

    chk_start_dest_first: assert property (@(posedge sys_clk) disable iff (rst)
        encOpen |=> encFirstOctet ##0 encBusy)
        else $error("Encoder did not begin at first destination octet");
    chk_ext_only_last: assert property (@(posedge sys_clk) disable iff (rst)
        pushed |-> (encOctet[0] == encLastOct))
        else $error("Extension bit set off the final octet");
    chk_pad_space: assert property (@(posedge sys_clk) disable iff (rst)
        pushed && tx_reg.pos != `SSID_POS && tx_reg.pos >= encLen |-> encOctet == 8'h40)
        else $error("Short call sign not padded with space");
    chk_reserved_ones: assert property (@(posedge sys_clk) disable iff (rst)
        pushed && tx_reg.pos == `SSID_POS |-> encOctet[6:5] == 2'h3)
        else $error("Reserved bits not driven high");
    chk_default_ssid: assert property (@(posedge sys_clk) disable iff (rst)
        pushed && tx_reg.sub == 4'd1 && tx_reg.pos == `SSID_POS && !srcSsidSet |-> encOctet[4:1] == 4'h0)
        else $error("Default identifier is not zero");
    chk_hbit_clear: assert property (@(posedge sys_clk) disable iff (rst)
        pushed && tx_reg.sub > 4'd1 && tx_reg.pos == `SSID_POS |-> !encOctet[7])
        else $error("Has-been-repeated bit sent set");
    chk_src_ext_chain: assert property (@(posedge sys_clk) disable iff (rst)
        pushed && tx_reg.sub == 4'd1 && tx_reg.pos == `SSID_POS && rptUsed != 4'd0 |-> !encOctet[0])
        else $error("Source extension bit set with repeaters present");
    chk_bit_lsb_first: assert property (@(posedge sys_clk) disable iff (rst)
        txBitValid && txBitReady && tx_reg.bitCnt != 3'd7 |=> txBit == $past(tx_reg.shReg[1]))
        else $error("Bits not sent least significant first");
    chk_early_dest: assert property (@(posedge sys_clk) disable iff (rst)
        rxStart ##1 (rxValid && !rxStart && rx_reg.state == PAR_ADDR)[*7] |=> destChecked)
        else $error("Destination verdict not given after seven octets");
    chk_bad_length: assert property (@(posedge sys_clk) disable iff (rst)
        !rxStart && rxEnd && rx_reg.pos != `SSID_POS |=> addrDone && addrError && frameDrop)
        else $error("Odd address length not rejected");
    chk_uplink_drop: assert property (@(posedge sys_clk) disable iff (rst)
        !rxStart && rxEnd && rx_reg.pos == `SSID_POS && viaRepeater && rx_reg.sub > 4'd1 &&
        !rxOctet[7] |=> addrDone && frameDrop)
        else $error("Up-link frame not discarded");
endmodule // packet_address_field_codec

// ===== hdl/addr_codec_cfg.svh
`ifndef ADDR_CODEC_CFG_SVH
`define ADDR_CODEC_CFG_SVH

// Subfield geometry
`define SUB_OCTETS     3'd7
`define CALL_CHARS     3'd6
`define SSID_POS       3'd6
`define MAX_RPT        8
`define MAX_SUBS       4'd10
`define CHAR_W         7
`define OCT_W          8

// Identifier octet fields
`define BIT_EXT        0
`define SSID_LSB       1
`define SSID_MSB       4
`define RSV_LSB        5
`define RSV_MSB        6
`define BIT_TOP        7

// Fixed values
`define CHAR_SPACE     7'h20
`define RSV_DEFAULT    2'h3
`define SSID_DEFAULT   4'h0
`define HBIT_TX        1'h0

// Data path buffering
`define FIFO_DEPTH     16

`endif

// ===== hdl/addr_codec_pkg.sv
package addr_codec_pkg;

    typedef enum logic [0:0] {ENC_IDLE, ENC_RUN} enc_state_type;
    typedef enum logic [1:0] {PAR_IDLE, PAR_ADDR, PAR_REST} par_state_type;

    typedef struct packed {
        enc_state_type state;
        logic [3:0]    sub;
        logic [2:0]    pos;
        logic          busy;
        logic [7:0]    shReg;
        logic [2:0]    bitCnt;
        logic          lastOct;
        logic          txValid;
        logic          txLast;
    } tx_state_type;

    typedef struct packed {
        par_state_type state;
        logic [3:0]    sub;
        logic [2:0]    pos;
        logic          match;
        logic          lastH;
        logic          charBad;
        logic          done;
        logic          error;
        logic          drop;
        logic          forUs;
        logic          destChecked;
        logic [3:0]    rptCount;
        logic [3:0]    srcSsid;
        logic          destCr;
        logic          srcCr;
    } rx_state_type;

endpackage

// ===== hdl/octet_fifo.sv
module octet_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic             doPush;
    logic             doPop;

    // Full and empty come straight from the occupancy count
    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // Pointers and occupancy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
            end
            if (doPop) begin
                rdPtr_reg <= AW'(rdPtr_reg + 1'b1);
            end
            count_reg <= (AW+1)'(count_reg + (AW+1)'(doPush) - (AW+1)'(doPop));
        end
    end

    // Storage needs no reset, contents are qualified by the count
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule // octet_fifo

// ===== dv/remote_station_model.sv
module remote_station_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Bit stream from the codec
    input  wire logic txBit,
    input  wire logic txBitValid,
    input  wire logic txLast,
    output logic      txBitReady,
    // Pace: high takes a bit only every other cycle
    input  wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got[$];
    logic       lastSeen[$];
    logic [7:0] shReg;
    logic [2:0] bitCnt;

    // Rebuild octets; a slow pace proves the codec holds each bit until taken
    always @(posedge sys_clk) begin
        if (rst) begin
            bitCnt <= 3'h0;
            txBitReady <= 1'b0;
        end else begin
            txBitReady <= slow ? ~txBitReady : 1'b1;
            if (txBitValid && txBitReady) begin
                shReg = {txBit, shReg[7:1]};
                bitCnt <= bitCnt + 3'h1;
                if (bitCnt == 3'h7) begin
                    got.push_back(shReg);
                    lastSeen.push_back(txLast);
                end
            end
        end
    end
endmodule // remote_station_model

// ===== dv/test_packet_address_field_codec.sv
`define CHECK(what, exp, seen) begin checked++; if ((seen) !== (exp)) begin errCount++; \
    $display("BAD %s expected %h seen %h", what, exp, seen); end end

module test_packet_address_field_codec;
    timeunit 1ns;
    timeprecision 1ps;

    logic         sys_clk, rst, encStart, destCr, srcSsidSet, srcCr, encBusy, slow;
    logic [41:0]  destCall, srcCall, ownCall;
    logic [2:0]   destLen, srcLen, ownLen;
    logic [3:0]   destSsid, srcSsid, rptCount, ownSsid, rxRptCount, rxSrcSsid;
    logic [335:0] rptCall;
    logic [23:0]  rptLen;
    logic [31:0]  rptSsid;
    logic         txBit, txBitValid, txLast, txBitReady, rxStart, rxValid, viaRepeater;
    logic [7:0]   rxOctet;
    logic         destChecked, addrForUs, addrDone, addrError, frameDrop, rxDestCr, rxSrcCr;
    logic         doneSeen, destSeen;
    logic [7:0]   expQ[$];
    int           errCount, checked;

    packet_address_field_codec packet_address_field_codec_i (.sys_clk, .rst, .encStart, .destCall,
        .destLen, .destSsid, .destCr, .srcCall, .srcLen, .srcSsid, .srcSsidSet, .srcCr, .rptCount,
        .rptCall, .rptLen, .rptSsid, .encBusy, .txBit, .txBitValid, .txLast, .txBitReady, .rxStart,
        .rxOctet, .rxValid, .ownCall, .ownLen, .ownSsid, .viaRepeater, .destChecked, .addrForUs,
        .addrDone, .addrError, .frameDrop, .rxRptCount, .rxSrcSsid, .rxDestCr, .rxSrcCr);

    remote_station_model remote_station_model_i (.sys_clk, .rst, .txBit, .txBitValid, .txLast,
        .txBitReady, .slow);

    // Free-running 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    // Latch the one-cycle result pulses so a task can judge them later
    always @(posedge sys_clk) begin
        if (addrDone) doneSeen <= 1'b1;
        if (destChecked) destSeen <= 1'b1;
    end

    function automatic logic [41:0] pack(input string s);
        byte c;
        pack = '0;
        for (int i = 0; i < s.len(); i++) begin
            c = s[i];
            pack[7*i +: 7] = c[6:0];
        end
    endfunction

    // Expected subfield: shifted characters, space padding, then the identifier octet
    function automatic void add_sub(input string s, input logic top, input logic [3:0] id, input logic ext);
        byte c;
        for (int i = 0; i < 6; i++) begin
            c = (i < s.len()) ? s[i] : 8'h20;
            expQ.push_back({c[6:0], 1'b0});
        end
        expQ.push_back({top, 2'h3, id, ext});
    endfunction

    task automatic run_tx(input logic pace, input logic [3:0] nRpt);
        int n;
        int k;
        n = 7 * (2 + nRpt);
        remote_station_model_i.got.delete();
        remote_station_model_i.lastSeen.delete();
        @(posedge sys_clk);
        slow <= pace;
        rptCount <= nRpt;
        encStart <= 1'b1;
        @(posedge sys_clk);
        encStart <= 1'b0;
        #1;
        `CHECK("busy", 1'b1, encBusy)
        for (k = 0; k < 4000 && remote_station_model_i.got.size() < n; k++) @(posedge sys_clk);
        `CHECK("octet count", n, remote_station_model_i.got.size())
        for (k = 0; k < n; k++) begin
            `CHECK("octet", expQ[k], remote_station_model_i.got[k])
            `CHECK("last flag", (k == n - 1), remote_station_model_i.lastSeen[k])
        end
        `CHECK("busy end", 1'b0, encBusy)
    endtask

    task tx_plain;
        @(posedge sys_clk);
        destCall <= pack("K8MMO");
        destLen <= 3'h5;
        destCr <= 1'b1;
        srcCall <= pack("WB4JFI");
        srcSsid <= 4'h5;
        srcSsidSet <= 1'b0;
        expQ.delete();
        add_sub("K8MMO", 1'b1, 4'h0, 1'b0);
        add_sub("WB4JFI", 1'b0, 4'h0, 1'b1);
        run_tx(1'b0, 4'h0);
    endtask

    // Longest chain, one-character destination, stalling station
    task tx_chain;
        @(posedge sys_clk);
        destCall <= pack("A");
        destLen <= 3'h1;
        destCr <= 1'b0;
        srcSsidSet <= 1'b1;
        srcSsid <= 4'h9;
        srcCr <= 1'b1;
        expQ.delete();
        add_sub("A", 1'b0, 4'h0, 1'b0);
        add_sub("WB4JFI", 1'b1, 4'h9, 1'b0);
        for (int r = 0; r < 8; r++) begin
            rptCall[r*42 +: 42] <= pack("WB4JFI");
            rptLen[r*3 +: 3] <= 3'h6;
            rptSsid[r*4 +: 4] <= 4'(r);
            add_sub("WB4JFI", 1'b0, 4'(r), r == 7);
        end
        run_tx(1'b1, 4'h8);
    endtask

    task automatic rx_run(input logic via, expFor, expErr, expDrop, input logic [3:0] expRpt, expSsid);
        @(posedge sys_clk);
        viaRepeater <= via;
        rxStart <= 1'b1;
        doneSeen = 1'b0;
        destSeen = 1'b0;
        foreach (expQ[i]) begin
            @(posedge sys_clk);
            rxStart <= 1'b0;
            rxValid <= 1'b1;
            rxOctet <= expQ[i];
            if (i == 11 && !expErr) `CHECK("early dest", 1'b1, destSeen)
        end
        @(posedge sys_clk);
        rxValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHECK("done", 1'b1, doneSeen)
        `CHECK("error", expErr, addrError)
        `CHECK("drop", expDrop, frameDrop)
        `CHECK("for us", expFor, addrForUs)
        if (!expErr) `CHECK("repeaters", expRpt, rxRptCount)
        if (!expErr) `CHECK("source id", expSsid, rxSrcSsid)
    endtask

    task rx_repeated(input logic h);
        expQ.delete();
        add_sub("K8MMO", 1'b1, 4'h0, 1'b0);
        add_sub("WB4JFI", 1'b0, 4'h0, 1'b0);
        add_sub("WB4JFI", h, 4'h1, 1'b1);
        rx_run(1'b1, 1'b1, 1'b0, !h, 4'h1, 4'h0);
        `CHECK("dest cr", 1'b1, rxDestCr)
        `CHECK("src cr", 1'b0, rxSrcCr)
    endtask

    // Identifier differs from ours; repeaters present on air but none in this frame
    task rx_other;
        ownSsid <= 4'h3;
        expQ.delete();
        add_sub("K8MMO", 1'b0, 4'h0, 1'b0);
        add_sub("W2XYZ", 1'b0, 4'h5, 1'b1);
        rx_run(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h5);
        ownSsid <= 4'h0;
    endtask

    task rx_bad_ext;
        expQ.delete();
        add_sub("K8MMO", 1'b1, 4'h0, 1'b0);
        add_sub("WB4JFI", 1'b0, 4'h0, 1'b1);
        expQ[2] = 8'h9b;
        rx_run(1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
    endtask

    // Ten subfields with no closing extension flag fill the longest legal field unterminated
    task rx_too_long;
        expQ.delete();
        for (int s = 0; s < 10; s++) add_sub("K8MMO", 1'b1, 4'h0, 1'b0);
        rx_run(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 4'h0);
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the longest expected run
    initial begin
        #1ms;
        errCount++;
        close_out;
    end

    // Reset, then the scenarios in turn
    initial begin
        {sys_clk, encStart, destCr, srcSsidSet, srcCr, slow, rxStart, rxValid, viaRepeater} = '0;
        {destCall, srcCall, destLen, srcLen, destSsid, srcSsid, rptCount} = '0;
        {rptCall, rptLen, rptSsid, rxOctet, ownSsid} = '0;
        ownCall = pack("K8MMO");
        ownLen = 3'h5;
        srcLen = 3'h6;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        tx_plain();
        tx_chain();
        rx_repeated(1'b1);
        rx_repeated(1'b0);
        rx_other();
        rx_bad_ext();
        rx_too_long();
        close_out;
    end
endmodule // test_packet_address_field_codec
